// >>> core/op_timer.sv
`timescale 1ns/100ps
// ==========================================
// one-shot delay: done pulses CYCLES edges after start
module op_timer
  import remap_pkg::*;
#(
  parameter int CYCLES = OP_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("op_timer: CYCLES must be at least 1");
  end

  // a new start restarts the count, so the latest request is the one served
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == CW'(1)) && !start;
endmodule

// >>> core/remap_global_status_ctrl.sv
`timescale 1ns/100ps
// ==========================================
// global command / status register bank
// Operation
// RULE1 - command bit 23: 0 blocks compatibility interrupts, 1 passes them through
// RULE2 - compatibility setting acts only with remapping on and extended mode off
// RULE3 - status mirrors the compatibility setting after each update
// RULE4 - compatibility control bit reads back undefined (here zero)
// RULE5 - when flushing is required, flush write buffers before any invalidation
// RULE6 - status bit 31 shows whether DMA remapping is enabled; read-only
// RULE7 - root pointer status clears when the set-root-pointer command is written
// RULE8 - root pointer status sets only after the root pointer is latched
// RULE9 - fault log status bit 29 clears on the set-fault-log command
// RULE10 - fault log status sets when the fault log pointer load completes
// RULE11 - status bit 28 shows advanced fault logging enabled, where supported
// RULE12 - flush status bit 27 sets on the write-buffer-flush command
// RULE13 - flush status clears when write-buffer flushing completes
// RULE14 - status bit 26 shows queued invalidation enabled
// RULE15 - global status sits at offset 01Ch and is read-only
// RULE16 - status bit 23: 0 blocked, 1 passed through
// RULE17 - zero command bits start nothing; reserved bits read zero, writes ignored
module remap_global_status_ctrl
  import remap_pkg::*;
#(
  parameter int PTR_W = 64,
  parameter bit WBUF_REQUIRED = 1'b1,
  parameter bit ADV_FAULT_LOG = 1'b1,
  parameter bit QUEUED_INVAL = 1'b1,
  parameter int OP_LEN = OP_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // table pointer sources and loaded pointers
  input wire logic [PTR_W-1:0] root_table_addr,
  input wire logic [PTR_W-1:0] fault_log_addr,
  output logic [PTR_W-1:0] root_ptr,
  output logic [PTR_W-1:0] fault_log_ptr,
  // enables seen by the translation logic
  output logic translation_on,
  output logic adv_fault_log_on,
  output logic queued_inval_on,
  // interrupt remapping context
  input wire logic ir_enabled,
  input wire logic ext_irq_mode,
  output logic compat_pass,
  // write buffer flush handshake
  output logic wbuf_flush_req,
  input wire logic wbuf_flush_done,
  // invalidation gate
  input wire logic inval_req,
  output logic inval_start
);
  // ==========================================
  // elaboration checks
  if (PTR_W < 1 || PTR_W > 64) begin : g_bad_ptr_w
    $error("PTR_W must be 1..64");
  end
  if (OP_LEN < 1) begin : g_bad_op_len
    $error("OP_LEN must be at least 1");
  end

  // ==========================================
  // write channel
  logic aw_held_r;
  logic [11:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  wire wr_fire;
  wire cmd_wr;
  wire wr_mapped;
  wire [31:0] wmask;
  wire [31:0] bit_wr;
  wire [31:0] bit_set;

  // address and data are taken in either order; response only after both
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign cmd_wr = wr_fire && (awaddr_r == CMD_OFF);
  assign wr_mapped = (awaddr_r == CMD_OFF) || (awaddr_r == STS_OFF);

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{wstrb_r[gb]}};
    end
  endgenerate

  // only strobed lanes of a command write count; a zero bit starts nothing
  assign bit_wr = cmd_wr ? wmask : 32'h0000_0000; // see RULE17
  assign bit_set = bit_wr & wdata_r; // see RULE17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // a write to the status word is accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR; // see RULE15
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // ==========================================
  // level enables
  logic te_r;
  logic afl_r;
  logic qie_r;
  logic cf_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      te_r <= STS_RESET[TE_BIT];
      afl_r <= STS_RESET[AFL_BIT];
      qie_r <= STS_RESET[QIE_BIT];
      cf_r <= STS_RESET[CF_BIT];
    end else begin
      if (bit_wr[TE_BIT]) te_r <= wdata_r[TE_BIT]; // see RULE6
      if (bit_wr[AFL_BIT]) afl_r <= ADV_FAULT_LOG && wdata_r[AFL_BIT]; // see RULE11
      if (bit_wr[QIE_BIT]) qie_r <= QUEUED_INVAL && wdata_r[QIE_BIT]; // see RULE14
      if (bit_wr[CF_BIT]) cf_r <= wdata_r[CF_BIT]; // see RULE3
    end
  end

  assign translation_on = te_r;
  assign adv_fault_log_on = afl_r;
  assign queued_inval_on = qie_r;
  // outside remapping, or in extended mode, the stored setting has no effect
  assign compat_pass = cf_r && ir_enabled && !ext_irq_mode; // see RULE1, see RULE2

  // ==========================================
  // pointer loads: root table (0) and fault log (1)
  wire [1:0] ptr_start;
  wire [1:0] ptr_done;
  wire [PTR_W-1:0] ptr_src [2];
  logic [PTR_W-1:0] ptr_r [2];
  logic [1:0] ptr_state_r;

  assign ptr_start[0] = bit_set[ROOT_PTR_BIT];
  assign ptr_start[1] = bit_set[FAULT_LOG_BIT];
  assign ptr_src[0] = root_table_addr;
  assign ptr_src[1] = fault_log_addr;

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_ptr
      op_timer #(
        .CYCLES(OP_LEN)
      ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(ptr_start[gp]),
        .busy(),
        .done(ptr_done[gp])
      );

      // the pointer is latched on the same edge the status is raised,
      // so software never sees the status ahead of the new pointer
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ptr_r[gp] <= '0;
          ptr_state_r[gp] <= 1'b0;
        end else if (ptr_start[gp]) begin
          ptr_state_r[gp] <= 1'b0; // see RULE7, see RULE9
        end else if (ptr_done[gp]) begin
          ptr_r[gp] <= ptr_src[gp]; // see RULE8, see RULE10
          ptr_state_r[gp] <= 1'b1; // see RULE8, see RULE10
        end
      end
    end
  endgenerate

  assign root_ptr = ptr_r[0];
  assign fault_log_ptr = ptr_r[1];

  // ==========================================
  // write buffer flush and invalidation gate
  inval_state_type inv_state_r;
  inval_state_type inv_state_nxt;
  logic flush_req_r;
  logic wbuf_flush_state_r;
  wire wbuf_flush_cmd;
  wire inv_flush_start;

  assign wbuf_flush_cmd = WBUF_REQUIRED && bit_set[WBUF_FLUSH_BIT];
  assign inv_flush_start = (inv_state_r == INV_IDLE) && inval_req && WBUF_REQUIRED;

  always_comb begin
    inv_state_nxt = inv_state_r;
    case (inv_state_r)
      INV_IDLE: begin
        if (inval_req) begin
          inv_state_nxt = WBUF_REQUIRED ? INV_FLUSH : INV_GO; // see RULE5
        end
      end
      INV_FLUSH: begin
        if (wbuf_flush_done) inv_state_nxt = INV_GO; // see RULE5
      end
      INV_GO: inv_state_nxt = INV_IDLE;
      default: inv_state_nxt = INV_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inv_state_r <= INV_IDLE;
    end else begin
      inv_state_r <= inv_state_nxt;
    end
  end

  // one request line serves both explicit and implicit flushes; a new
  // request on the completion edge keeps it raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_req_r <= 1'b0;
    end else if (wbuf_flush_cmd || inv_flush_start) begin
      flush_req_r <= 1'b1;
    end else if (wbuf_flush_done) begin
      flush_req_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wbuf_flush_state_r <= STS_RESET[WBUF_FLUSH_BIT];
    end else if (wbuf_flush_cmd) begin
      wbuf_flush_state_r <= 1'b1; // see RULE12
    end else if (wbuf_flush_done) begin
      wbuf_flush_state_r <= 1'b0; // see RULE13
    end
  end

  assign wbuf_flush_req = flush_req_r;
  assign inval_start = (inv_state_r == INV_GO);

  // ==========================================
  // read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire [31:0] status_w;
  wire rd_sts;
  wire rd_mapped;

  // bits 22:0 are reserved and read zero
  assign status_w = {te_r, ptr_state_r[0], ptr_state_r[1], afl_r, wbuf_flush_state_r, qie_r,
                     2'b00, cf_r, 23'h00_0000}; // see RULE6, see RULE16, see RULE17
  assign rd_sts = (araddr == STS_OFF); // see RULE15
  assign rd_mapped = rd_sts || (araddr == CMD_OFF);
  assign arready = !rvalid_r;

  // the command word reads as zero, since its value is not defined
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_sts ? status_w : 32'h0000_0000; // see RULE4
      rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
endmodule

// >>> shared/remap_pkg.sv
// ==========================================
// constants shared by the status/command bank
package remap_pkg;
  // register byte addresses
  localparam logic [11:0] CMD_OFF = 12'h018;
  localparam logic [11:0] STS_OFF = 12'h01c;
  // bit positions, same in command and status words
  localparam int TE_BIT = 31;
  localparam int ROOT_PTR_BIT = 30;
  localparam int FAULT_LOG_BIT = 29;
  localparam int AFL_BIT = 28;
  localparam int WBUF_FLUSH_BIT = 27;
  localparam int QIE_BIT = 26;
  localparam int CF_BIT = 23;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;
  // time to load a table pointer into the walker
  localparam int CLK_PERIOD_NS = 25;
  localparam int OP_TIME_NS = 100;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {INV_IDLE, INV_FLUSH, INV_GO} inval_state_type;
endpackage

// >>> verification/remap_global_status_ctrl_checker.sv
`timescale 1ns/100ps
// ==========================================
// port checks for the command/status bank
module remap_checker
  import remap_pkg::*;
#(
  parameter int PTR_W = 64,
  parameter int OP_LEN = OP_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [11:0] awaddr,
  input wire logic [31:0] wdata,
  // pointers
  input wire logic [PTR_W-1:0] root_table_addr,
  input wire logic [PTR_W-1:0] fault_log_addr,
  input wire logic [PTR_W-1:0] root_ptr,
  input wire logic [PTR_W-1:0] fault_log_ptr,
  // enables and handshakes
  input wire logic translation_on,
  input wire logic adv_fault_log_on,
  input wire logic queued_inval_on,
  input wire logic ir_enabled,
  input wire logic ext_irq_mode,
  input wire logic compat_pass,
  input wire logic wbuf_flush_req,
  input wire logic wbuf_flush_done,
  input wire logic inval_start
);
  // last taken write, so the apply edge can be judged against it
  logic [11:0] wa_r;
  logic [31:0] wd_r;
  always_ff @(posedge aclk) begin
    if (awvalid && awready) wa_r <= awaddr;
    if (wvalid && wready) wd_r <= wdata;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // command apply lands on the same edge that raises bvalid
  sequence s_cmd;
    $rose(bvalid) && wa_r == CMD_OFF;
  endsequence
  sequence s_sts;
    $rose(bvalid) && wa_r == STS_OFF;
  endsequence
  a_compat_gate: assert property (compat_pass |-> ir_enabled && !ext_irq_mode)
    else $error("compat pass outside its gate");
  a_compat_level: assert property (s_cmd |->
    compat_pass == (wd_r[CF_BIT] && ir_enabled && !ext_irq_mode)) else $error("compat wrong");
  a_enable_levels: assert property (s_cmd |-> translation_on == wd_r[TE_BIT] &&
    adv_fault_log_on == wd_r[AFL_BIT] && queued_inval_on == wd_r[QIE_BIT])
    else $error("enable level wrong");
  a_root_load: assert property (s_cmd ##0 wd_r[ROOT_PTR_BIT] |->
    ##OP_LEN root_ptr == root_table_addr) else $error("root pointer not loaded");
  a_fault_load: assert property (s_cmd ##0 wd_r[FAULT_LOG_BIT] |->
    ##OP_LEN fault_log_ptr == fault_log_addr) else $error("fault log pointer not loaded");
  a_flush_set: assert property (s_cmd ##0 wd_r[WBUF_FLUSH_BIT] |-> wbuf_flush_req)
    else $error("flush request missing");
  a_status_ro: assert property (s_sts |-> $stable(translation_on) &&
    $stable(queued_inval_on)) else $error("status write had effect");
  a_inval_flushed: assert property (inval_start |-> $past(wbuf_flush_done))
    else $error("invalidation before flush");
  a_inval_pulse: assert property (inval_start |=> !inval_start)
    else $error("invalidation start too long");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule

bind remap_global_status_ctrl remap_checker #(
  .PTR_W(PTR_W),
  .OP_LEN(OP_LEN)
) i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .arvalid(arvalid),
  .arready(arready),
  .rvalid(rvalid),
  .awaddr(awaddr),
  .wdata(wdata),
  .root_table_addr(root_table_addr),
  .fault_log_addr(fault_log_addr),
  .root_ptr(root_ptr),
  .fault_log_ptr(fault_log_ptr),
  .translation_on(translation_on),
  .adv_fault_log_on(adv_fault_log_on),
  .queued_inval_on(queued_inval_on),
  .ir_enabled(ir_enabled),
  .ext_irq_mode(ext_irq_mode),
  .compat_pass(compat_pass),
  .wbuf_flush_req(wbuf_flush_req),
  .wbuf_flush_done(wbuf_flush_done),
  .inval_start(inval_start)
);

// >>> verification/remap_global_status_ctrl_tb_top.sv
`timescale 1ns/100ps
module remap_global_status_ctrl_tb_top;
  import remap_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ir_enabled = 1'b0, ext_irq_mode = 1'b0;
  logic wbuf_flush_done = 1'b0, inval_req = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [63:0] root_table_addr = 64'h0, fault_log_addr = 64'h0;
  logic awready, wready, bvalid, arready, rvalid, translation_on, adv_fault_log_on;
  logic queued_inval_on, compat_pass, wbuf_flush_req, inval_start;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [63:0] root_ptr, fault_log_ptr;
  int errors = 0, checks = 0;
  always #12.5 aclk = ~aclk;
  remap_global_status_ctrl i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .root_table_addr(root_table_addr),
    .fault_log_addr(fault_log_addr),
    .root_ptr(root_ptr),
    .fault_log_ptr(fault_log_ptr),
    .translation_on(translation_on),
    .adv_fault_log_on(adv_fault_log_on),
    .queued_inval_on(queued_inval_on),
    .ir_enabled(ir_enabled),
    .ext_irq_mode(ext_irq_mode),
    .compat_pass(compat_pass),
    .wbuf_flush_req(wbuf_flush_req),
    .wbuf_flush_done(wbuf_flush_done),
    .inval_req(inval_req),
    .inval_start(inval_start)
  );
  // ==========================================
  // shared helpers
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // only the watchdog ends a wait for an answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", r, bresp);
    // an idle edge, so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", r, rresp);
    chk("rdata", d, rdata);
    @(posedge aclk);
  endtask
  task automatic pulse_done();
    wbuf_flush_done <= 1'b1;
    @(posedge aclk);
    wbuf_flush_done <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset_vals();
    rd(STS_OFF, 32'h0, RESP_OKAY);
    rd(CMD_OFF, 32'h0, RESP_OKAY);
    wr(12'h040, 32'hffff_ffff, RESP_SLVERR);
    rd(12'h040, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_levels();
    ir_enabled <= 1'b1;
    wr(CMD_OFF, 32'h97ff_ffff, RESP_OKAY);
    rd(STS_OFF, 32'h9480_0000, RESP_OKAY);
    chk("compat_pass", 1'b1, compat_pass);
    chk("translation_on", 1'b1, translation_on);
    chk("adv_fault_log_on", 1'b1, adv_fault_log_on);
    chk("queued_inval_on", 1'b1, queued_inval_on);
    ext_irq_mode <= 1'b1;
    @(posedge aclk);
    chk("compat_pass", 1'b0, compat_pass);
    wr(STS_OFF, 32'h0, RESP_OKAY);
    rd(STS_OFF, 32'h9480_0000, RESP_OKAY);
    ext_irq_mode <= 1'b0;
    wr(CMD_OFF, 32'h0, RESP_OKAY);
    chk("compat_pass", 1'b0, compat_pass);
    rd(STS_OFF, 32'h0, RESP_OKAY);
  endtask
  task automatic t_flush();
    wr(CMD_OFF, 32'h0800_0000, RESP_OKAY);
    chk("wbuf_flush_req", 1'b1, wbuf_flush_req);
    rd(STS_OFF, 32'h0800_0000, RESP_OKAY);
    pulse_done();
    rd(STS_OFF, 32'h0, RESP_OKAY);
  endtask
  task automatic t_inval();
    inval_req <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!wbuf_flush_req);
    wbuf_flush_done <= 1'b1;
    @(posedge aclk);
    chk("inval_start", 1'b0, inval_start);
    wbuf_flush_done <= 1'b0;
    inval_req <= 1'b0;
    @(posedge aclk);
    chk("inval_start", 1'b1, inval_start);
  endtask
  task automatic t_ptr();
    root_table_addr <= 64'h0123_4567_89ab_c000;
    fault_log_addr <= 64'h0000_00fe_dcba_9000;
    wr(CMD_OFF, 32'h6000_0000, RESP_OKAY);
    repeat (OP_CYCLES + 2) @(posedge aclk);
    rd(STS_OFF, 32'h6000_0000, RESP_OKAY);
    chk("root_ptr", 64'h0123_4567_89ab_c000, root_ptr);
    chk("fault_log_ptr", 64'h0000_00fe_dcba_9000, fault_log_ptr);
    wr(CMD_OFF, 32'h4000_0000, RESP_OKAY);
    rd(STS_OFF, 32'h2000_0000, RESP_OKAY);
    repeat (OP_CYCLES + 2) @(posedge aclk);
    wr(CMD_OFF, 32'h2000_0000, RESP_OKAY);
    rd(STS_OFF, 32'h4000_0000, RESP_OKAY);
  endtask
  // ==========================================
  // run control
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_levels();
    t_flush();
    t_inval();
    t_ptr();
    conclude();
  end
  // whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    conclude();
  end
endmodule
